// ---- ccw_card_clock_wakeup.sv ----
// card clock divider, internal clock control and wakeup enables
//
// Operation
// - wakeup register always present and accessible
// - bit 2 enables wakeup on card removal
// - bit 1 enables wakeup on card insertion
// - bit 0 enables wakeup on card interrupt
// - card support flag never gates removal/insertion
// - one-hot divisor field, 80h/256 down to 01h/2
// - code 00h passes undivided base clock
// - multiple divisor bits: highest bit wins
// - clearing card clock enable stops clock
// - card removal clears card clock enable
// - stable bit set after settle; gates card clock
// - internal clock enable off stops clock, registers live
//
// the base clock is core_clk_in divided by two; the card clock half
// period is the divisor in core cycles, so 00h gives base clock rate.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module ccw_card_clock_wakeup
(
   input  wire logic              core_clk_in,
   input  wire logic              rst_n_in,
   input  wire ccw_pkg::ccw_addr_t addr_in,
   input  wire ccw_pkg::ccw_data_t wr_data_in,
   input  wire logic              wr_strobe_in,
   input  wire logic              rd_strobe_in,
   output var  ccw_pkg::ccw_data_t rd_data_out,
   input  wire logic              card_removal_status_in,
   input  wire logic              card_insertion_status_in,
   input  wire logic              card_interrupt_status_in,
   input  wire logic              card_inserted_in,
   output var  logic              card_clk_out,
   output var  logic              wakeup_out,
   output var  logic              irq_out
);

   import ccw_pkg::*;

   typedef enum {CLK_STOPPED, CLK_RUNNING} ccw_clk_state_e;

   // highest set bit selects the divisor; zero means undivided
   function automatic ccw_half_t ccw_div_half(input logic [7:0] code);
      ccw_half_t half;
      half = 9'h001;
      for (int i = 0; i < 8; i++)
      begin
         if (code[i])
         begin
            half = 9'h002 << i;
         end
      end
      return half;
   endfunction : ccw_div_half

   // register state
   logic [2:0]     wake_en_reg;
   logic [7:0]     div_field_reg;
   logic           sdce_reg;
   logic           sdce_next;
   logic           ice_reg;
   logic           stable_reg;
   logic           stable_next;
   logic [6:0]     settle_cnt_reg;
   logic [6:0]     settle_cnt_next;
   logic           inserted_prev_reg;
   logic [2:0]     sts_reg;
   logic [2:0]     sts_next;
   logic [2:0]     mask_reg;
   logic           wakeup_reg;
   logic           irq_reg;
   ccw_data_t      rd_data_reg;

   // card clock generator state
   ccw_clk_state_e clk_state_reg;
   ccw_clk_state_e clk_state_next;
   logic [7:0]     active_div_reg;
   logic [7:0]     active_div_next;
   ccw_half_t      half_cnt_reg;
   ccw_half_t      half_cnt_next;
   logic           card_clk_reg;
   logic           card_clk_next;

   // address decode
   wire logic hit_wake   = (addr_in == CCW_WAKEUP_ADDR);
   wire logic hit_clkctl = (addr_in == CCW_CLKCTL_ADDR);
   wire logic hit_sts    = (addr_in == CCW_IRQ_STATUS_ADDR);
   wire logic hit_mask   = (addr_in == CCW_IRQ_MASK_ADDR);

   wire logic wr_wake    = wr_strobe_in & hit_wake;
   wire logic wr_clkctl  = wr_strobe_in & hit_clkctl;
   wire logic wr_sts     = wr_strobe_in & hit_sts;
   wire logic wr_mask    = wr_strobe_in & hit_mask;

   // wakeup condition; card support flag takes no part here
   wire logic wake_rem = wake_en_reg[CCW_WK_REM_BIT]
                         & card_removal_status_in;
   wire logic wake_ins = wake_en_reg[CCW_WK_INS_BIT]
                         & card_insertion_status_in;
   wire logic wake_int = wake_en_reg[CCW_WK_INT_BIT]
                         & card_interrupt_status_in;
   wire logic wake_cond = wake_rem | wake_ins | wake_int;

   // card inserted falling edge clears the card clock enable
   wire logic removed_edge = inserted_prev_reg & ~card_inserted_in;

   // card clock may run only with internal clock up and stable
   wire logic run_req = sdce_reg & ice_reg & stable_reg;

   wire ccw_half_t half_period = ccw_div_half(active_div_reg);
   wire logic      half_done   = (half_cnt_reg == half_period - 9'h001);

   // events into the sticky status
   wire logic [2:0] ev_set;
   assign ev_set[CCW_EV_WAKEUP_BIT]   = wake_cond & ~wakeup_reg;
   assign ev_set[CCW_EV_STABLE_BIT]   = stable_next & ~stable_reg;
   assign ev_set[CCW_EV_AUTOSTOP_BIT] = removed_edge & sdce_reg;

   // read mux; unmapped addresses read zero
   wire ccw_data_t rd_value =
      hit_wake   ? {13'h0000, wake_en_reg} :
      hit_clkctl ? {div_field_reg, 5'h00, sdce_reg, stable_reg, ice_reg} :
      hit_sts    ? {13'h0000, sts_reg} :
      hit_mask   ? {13'h0000, mask_reg} :
                   16'h0000;

   // card clock enable: removal clear beats a software write
   always_comb
   begin
      sdce_next = sdce_reg;
      if (removed_edge)
      begin
         sdce_next = 1'b0;
      end
      else if (wr_clkctl)
      begin
         sdce_next = wr_data_in[CCW_CC_SDCE_BIT];
      end
   end

   // settle counter for the internal clock stable flag
   always_comb
   begin
      settle_cnt_next = settle_cnt_reg;
      stable_next     = stable_reg;
      if (!ice_reg)
      begin
         settle_cnt_next = 7'h00;
         stable_next     = 1'b0;
      end
      else if (!stable_reg)
      begin
         if (settle_cnt_reg == CCW_STABLE_CYCLES - 7'h01)
         begin
            stable_next = 1'b1;
         end
         else
         begin
            settle_cnt_next = settle_cnt_reg + 7'h01;
         end
      end
   end

   // sticky status: set wins over write-one-to-clear
   always_comb
   begin
      sts_next = sts_reg;
      if (wr_sts)
      begin
         sts_next = sts_reg & ~wr_data_in[2:0];
      end
      sts_next = sts_next | ev_set;
   end

   // card clock generator; stops only at the low level
   always_comb
   begin
      clk_state_next  = clk_state_reg;
      active_div_next = active_div_reg;
      half_cnt_next   = half_cnt_reg;
      card_clk_next   = card_clk_reg;
      case (clk_state_reg)
         CLK_STOPPED:
         begin
            card_clk_next   = 1'b0;
            half_cnt_next   = 9'h000;
            active_div_next = div_field_reg;
            if (run_req)
            begin
               clk_state_next = CLK_RUNNING;
            end
         end
         CLK_RUNNING:
         begin
            if (!card_clk_reg && !run_req)
            begin
               clk_state_next = CLK_STOPPED;
               half_cnt_next  = 9'h000;
            end
            else if (half_done)
            begin
               half_cnt_next = 9'h000;
               card_clk_next = ~card_clk_reg;
            end
            else
            begin
               half_cnt_next = half_cnt_reg + 9'h001;
            end
         end
         default:
         begin
            clk_state_next = CLK_STOPPED;
         end
      endcase
   end

   // software registers
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wake_en_reg   <= CCW_WAKEUP_RST;
         div_field_reg <= CCW_DIV_RST;
         ice_reg       <= CCW_ICE_RST;
         mask_reg      <= CCW_MASK_RST;
      end
      else
      begin
         if (wr_wake)
         begin
            wake_en_reg <= wr_data_in[2:0];
         end
         if (wr_clkctl)
         begin
            div_field_reg <= wr_data_in[CCW_CC_DIV_MSB:CCW_CC_DIV_LSB];
            ice_reg       <= wr_data_in[CCW_CC_ICE_BIT];
         end
         if (wr_mask)
         begin
            mask_reg <= wr_data_in[2:0];
         end
      end
   end

   // hardware state
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sdce_reg          <= CCW_SDCE_RST;
         stable_reg        <= 1'b0;
         settle_cnt_reg    <= 7'h00;
         inserted_prev_reg <= 1'b0;
         sts_reg           <= 3'h0;
      end
      else
      begin
         sdce_reg          <= sdce_next;
         stable_reg        <= stable_next;
         settle_cnt_reg    <= settle_cnt_next;
         inserted_prev_reg <= card_inserted_in;
         sts_reg           <= sts_next;
      end
   end

   // card clock generator registers
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         clk_state_reg  <= CLK_STOPPED;
         active_div_reg <= CCW_DIV_RST;
         half_cnt_reg   <= 9'h000;
         card_clk_reg   <= 1'b0;
      end
      else
      begin
         clk_state_reg  <= clk_state_next;
         active_div_reg <= active_div_next;
         half_cnt_reg   <= half_cnt_next;
         card_clk_reg   <= card_clk_next;
      end
   end

   // outputs
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wakeup_reg  <= 1'b0;
         irq_reg     <= 1'b0;
         rd_data_reg <= 16'h0000;
      end
      else
      begin
         wakeup_reg  <= wake_cond;
         irq_reg     <= |(sts_next & mask_reg);
         rd_data_reg <= rd_strobe_in ? rd_value : 16'h0000;
      end
   end

   assign rd_data_out  = rd_data_reg;
   assign card_clk_out = card_clk_reg;
   assign wakeup_out   = wakeup_reg;
   assign irq_out      = irq_reg;

endmodule : ccw_card_clock_wakeup

`default_nettype wire

// ---- ccw_card_clock_wakeup_asserts.sv ----
// port assertions for the card clock and wakeup block
`timescale 1ns/100ps
`default_nettype none
module ccw_card_clock_wakeup_asserts
   import ccw_pkg::*;
(
   input wire logic      core_clk_in,
   input wire logic      rst_n_in,
   input wire ccw_addr_t addr_in,
   input wire ccw_data_t wr_data_in,
   input wire logic      wr_strobe_in,
   input wire logic      rd_strobe_in,
   input wire ccw_data_t rd_data_out,
   input wire logic      card_removal_status_in,
   input wire logic      card_insertion_status_in,
   input wire logic      card_interrupt_status_in,
   input wire logic      card_inserted_in,
   input wire logic      card_clk_out,
   input wire logic      wakeup_out,
   input wire logic      irq_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence wr_wk_s;
      wr_strobe_in && addr_in == CCW_WAKEUP_ADDR;
   endsequence
   sequence rd_wk_s;
      rd_strobe_in && addr_in == CCW_WAKEUP_ADDR;
   endsequence
   rd_idle_a: assert property (
      !rd_strobe_in |=> rd_data_out == 16'h0000)
      else $error("read data not zero outside a read");
   wk_back_a: assert property (
      wr_wk_s ##1 rd_wk_s |=> rd_data_out[2:0] == $past(wr_data_in[2:0], 2))
      else $error("wakeup enables not read back");
   wk_rsvd_a: assert property (
      rd_wk_s |=> rd_data_out[15:3] == 13'h0000)
      else $error("wakeup reserved bits not zero");
   cc_rsvd_a: assert property (
      rd_strobe_in && addr_in == CCW_CLKCTL_ADDR |=> rd_data_out[7:3] == 5'h00)
      else $error("clock control reserved bits not zero");
   no_wake_a: assert property (
      !(card_removal_status_in || card_insertion_status_in ||
        card_interrupt_status_in) |=> !wakeup_out)
      else $error("wakeup without status");
   wk_off_a: assert property (
      wr_wk_s ##0 wr_data_in[2:0] == 3'h0 |=> ##1 !wakeup_out)
      else $error("wakeup with all enables off");
   irq_mask_a: assert property (
      wr_strobe_in && addr_in == CCW_IRQ_MASK_ADDR && wr_data_in[2:0] == 3'h0
      |=> ##1 !irq_out)
      else $error("interrupt with mask clear");
   rm_stop_a: assert property (
      !card_inserted_in [*4] |-> !$rose(card_clk_out))
      else $error("card clock rose after removal");
endmodule : ccw_card_clock_wakeup_asserts
bind ccw_card_clock_wakeup ccw_card_clock_wakeup_asserts u_chk (
   .core_clk_in, .rst_n_in, .addr_in, .wr_data_in, .wr_strobe_in,
   .rd_strobe_in, .rd_data_out, .card_removal_status_in,
   .card_insertion_status_in, .card_interrupt_status_in, .card_inserted_in,
   .card_clk_out, .wakeup_out, .irq_out);
`default_nettype wire

// ---- ccw_card_model.sv ----
// card side model: presence, card interrupt and clock period meter
`timescale 1ns/100ps
`default_nettype none
module ccw_card_model
#(parameter bit WAKE_SUPPORT = 1'b1)
(
   input  wire logic card_clk_in,
   input  wire logic insert_in,
   input  wire logic int_req_in,
   output var  logic inserted_out,
   output var  logic card_int_out,
   output var  int   rises_out,
   output var  int   period_out
);
   realtime last_t = 0;
   int      n_rise = 0;
   int      last_p = 0;
   assign inserted_out = insert_in;
   // interrupts only raised by a card that supports wakeup
   assign card_int_out = int_req_in & WAKE_SUPPORT;
   assign rises_out    = n_rise;
   assign period_out   = last_p;
   always @(posedge card_clk_in)
   begin
      last_p = int'($realtime - last_t);
      last_t = $realtime;
      n_rise = n_rise + 1;
   end
endmodule : ccw_card_model
`default_nettype wire

// ---- ccw_pkg.sv ----
// constants and types for the card clock and wakeup control block
`default_nettype none

package ccw_pkg;

   // register addresses (printed offsets, plain port addressing)
   localparam logic [7:0] CCW_WAKEUP_ADDR     = 8'h2B;
   localparam logic [7:0] CCW_CLKCTL_ADDR     = 8'h2C;
   localparam logic [7:0] CCW_IRQ_STATUS_ADDR = 8'h40;
   localparam logic [7:0] CCW_IRQ_MASK_ADDR   = 8'h41;

   // wakeup enable register fields
   localparam int CCW_WK_INT_BIT = 0;
   localparam int CCW_WK_INS_BIT = 1;
   localparam int CCW_WK_REM_BIT = 2;

   // clock control register fields
   localparam int CCW_CC_ICE_BIT    = 0;
   localparam int CCW_CC_STABLE_BIT = 1;
   localparam int CCW_CC_SDCE_BIT   = 2;
   localparam int CCW_CC_DIV_LSB    = 8;
   localparam int CCW_CC_DIV_MSB    = 15;

   // interrupt status / mask fields
   localparam int CCW_EV_WAKEUP_BIT   = 0;
   localparam int CCW_EV_STABLE_BIT   = 1;
   localparam int CCW_EV_AUTOSTOP_BIT = 2;

   // reset values
   localparam logic [2:0] CCW_WAKEUP_RST = 3'h0;
   localparam logic [7:0] CCW_DIV_RST    = 8'h00;
   localparam logic       CCW_ICE_RST    = 1'h0;
   localparam logic       CCW_SDCE_RST   = 1'h0;
   localparam logic [2:0] CCW_MASK_RST   = 3'h0;

   // timing
   localparam int CCW_CLK_PERIOD_NS   = 10;
   localparam int CCW_STABLE_TIME_NS  = 1000;
   localparam int CCW_STABLE_CYC_INT  =
      (CCW_STABLE_TIME_NS + CCW_CLK_PERIOD_NS - 1) / CCW_CLK_PERIOD_NS;
   localparam logic [6:0] CCW_STABLE_CYCLES = 7'(CCW_STABLE_CYC_INT);

   typedef logic [7:0]  ccw_addr_t;
   typedef logic [15:0] ccw_data_t;
   typedef logic [8:0]  ccw_half_t;

endpackage : ccw_pkg

`default_nettype wire

// ---- tb_card_clock_wakeup_ctrl.sv ----
// self-checking bench for the card clock and wakeup block
`timescale 1ns/100ps
`default_nettype none
module tb_card_clock_wakeup_ctrl;
   import ccw_pkg::*;
   logic core_clk_in = 1'b0, rst_n_in = 1'b0, wr_strobe_in = 1'b0;
   logic rd_strobe_in = 1'b0, rem = 1'b0, ins = 1'b0, irq_req = 1'b0;
   logic insert = 1'b1, card_int, card_ins, card_clk, wakeup_out, irq_out;
   ccw_addr_t addr_in = '0;
   ccw_data_t wr_data_in = '0, rd_data_out, d;
   int rises, period, n_fail = 0, n_compared = 0, wk_m, st_m = 0, h, k, v;
   int sel;
   int divs[6] = '{0, 1, 2, 8, 128, 3};
   ccw_addr_t ra[5] = '{CCW_WAKEUP_ADDR, CCW_CLKCTL_ADDR,
                        CCW_IRQ_STATUS_ADDR, CCW_IRQ_MASK_ADDR, 8'h30};
   always #5 core_clk_in = ~core_clk_in;
   ccw_card_clock_wakeup DUT (.core_clk_in, .rst_n_in, .addr_in,
      .wr_data_in, .wr_strobe_in, .rd_strobe_in, .rd_data_out,
      .card_removal_status_in(rem), .card_insertion_status_in(ins),
      .card_interrupt_status_in(card_int), .card_inserted_in(card_ins),
      .card_clk_out(card_clk), .wakeup_out, .irq_out);
   ccw_card_model u_card (.card_clk_in(card_clk), .insert_in(insert),
      .int_req_in(irq_req), .inserted_out(card_ins),
      .card_int_out(card_int), .rises_out(rises), .period_out(period));
   task automatic finish_test();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // write: strobe held one cycle; a following write waits one edge
   task automatic wr(ccw_addr_t a, ccw_data_t val);
      if (wr_strobe_in)
         @(posedge core_clk_in);
      addr_in <= a;
      wr_data_in <= val;
      wr_strobe_in <= 1'b1;
      @(posedge core_clk_in);
      wr_strobe_in <= 1'b0;
   endtask : wr
   task automatic rd(ccw_addr_t a);
      addr_in <= a;
      rd_strobe_in <= 1'b1;
      @(posedge core_clk_in);
      rd_strobe_in <= 1'b0;
      @(negedge core_clk_in);
      d = rd_data_out;
      @(posedge core_clk_in);
   endtask : rd
   task automatic look();
      @(posedge core_clk_in);
      @(negedge core_clk_in);
   endtask : look
   initial
   begin
      v = $urandom(32'hEBA0);
      repeat (16) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      @(posedge core_clk_in);
      wr(8'h30, 16'hFFFF);
      foreach (ra[i])
      begin
         rd(ra[i]);
         chk("reset_or_unmapped", 0, d);
      end
      repeat (4)
      begin
         v = $urandom;
         wk_m = v & 7;
         wr(CCW_WAKEUP_ADDR, 16'(v));
         rd(CCW_WAKEUP_ADDR);
         chk("wake_enables", wk_m, d);
         for (int s = 0; s < 8; s++)
         begin
            {rem, ins, irq_req} <= 3'(s);
            look();
            chk("wakeup", (wk_m & s) != 0, wakeup_out);
            if ((wk_m & s) != 0)
               st_m |= 1;
            @(posedge core_clk_in);
         end
         {rem, ins, irq_req} <= 3'h0;
      end
      wr(CCW_WAKEUP_ADDR, 16'h0000);
      rd(CCW_WAKEUP_ADDR);
      chk("wake_off", 0, d);
      wr(CCW_CLKCTL_ADDR, 16'h0003);
      rd(CCW_CLKCTL_ADDR);
      chk("stable_ro", 16'h0001, d);
      for (k = 0; k < 200 && !d[1]; k++)
         rd(CCW_CLKCTL_ADDR);
      chk("stable", 16'h0003, d);
      chk("settle_time", 1, k >= CCW_STABLE_CYC_INT / 2 - 1
                            && k <= CCW_STABLE_CYC_INT / 2 + 1);
      st_m |= 2;
      foreach (divs[i])
      begin
         h = 1;
         for (int b = 0; b < 8; b++)
            if (divs[i][b])
               h = 2 << b;
         wr(CCW_CLKCTL_ADDR, 16'(divs[i] << 8 | 1));
         wr(CCW_CLKCTL_ADDR, 16'(divs[i] << 8 | 5));
         k = rises + 3;
         for (int t = 0; t < 4000 && rises < k; t++)
            @(posedge core_clk_in);
         if (rises < k)
         begin
            n_fail++;
            finish_test();
         end
         chk("card_period", 20 * h, period);
         rd(CCW_CLKCTL_ADDR);
         chk("clk_ctl", divs[i] << 8 | 7, d);
         wr(CCW_CLKCTL_ADDR, 16'(divs[i] << 8 | 3));
         repeat (600) @(posedge core_clk_in);
         k = rises;
         repeat (600) @(posedge core_clk_in);
         chk("clk_stopped", k, rises);
      end
      // smallest divisor that keeps the card at or under 25 MHz
      sel = 0;
      for (int dv = 256; dv >= 1; dv = dv / 2)
         if (1000000 / (2 * CCW_CLK_PERIOD_NS) / dv <= 25000)
            sel = dv / 2;
      wr(CCW_CLKCTL_ADDR, 16'(sel << 8 | 5));
      repeat (20) @(posedge core_clk_in);
      chk("sel_period", 1, period >= 40);
      insert <= 1'b0;
      repeat (20) @(posedge core_clk_in);
      k = rises;
      rd(CCW_CLKCTL_ADDR);
      chk("auto_clear", sel << 8 | 3, d);
      repeat (20) @(posedge core_clk_in);
      chk("removed_stop", k, rises);
      insert <= 1'b1;
      rd(CCW_IRQ_STATUS_ADDR);
      chk("irq_status", st_m | 4, d);
      wr(CCW_IRQ_MASK_ADDR, 16'h0007);
      look();
      chk("irq_on", 1, irq_out);
      @(posedge core_clk_in);
      wr(CCW_IRQ_STATUS_ADDR, 16'h0007);
      rd(CCW_IRQ_STATUS_ADDR);
      chk("irq_cleared", 0, d);
      chk("irq_off", 0, irq_out);
      wr(CCW_IRQ_MASK_ADDR, 16'h0000);
      wr(CCW_CLKCTL_ADDR, 16'h0000);
      // the stable flag drops one cycle after the enable
      @(posedge core_clk_in);
      rd(CCW_CLKCTL_ADDR);
      chk("ice_off", 0, d);
      finish_test();
   end
endmodule : tb_card_clock_wakeup_ctrl
`default_nettype wire
